/* core/edc_ctrl.sv */
// Purpose: Controller driving an EDO DRAM module through its strobe and address pins.
// Assumes: Requests arrive synchronous to i_core_clk; module strapped to either grade.
// Notes: One random access per request; refresh has priority once due.
`timescale 1ns/1ns
module edc_ctrl
	import edc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [WORD_ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [3:0] i_be,
	input wire logic [DATA_W-1:0] i_data_lines,
	input wire logic [3:0] i_speed_id,
	output logic o_ready,
	output logic o_done,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_speed_ok,
	output logic [ADDR_W-1:0] o_mux_addr_lines,
	output logic [1:0] o_row_strobe_n,
	output logic [3:0] o_col_strobe_n,
	output logic o_write_strobe_n,
	output logic [DATA_W-1:0] o_data_lines,
	output logic o_data_lines_oe
);
	typedef struct packed
	{
		edc_state_e st;
		logic we;
		logic [WORD_ADDR_W-1:0] addr;
		logic [3:0] be;
		logic [REF_W-1:0] ref_cnt;
		logic ref_due;
		logic [CNT_W-1:0] cyc;
		logic ready;
		logic done;
		logic [DATA_W-1:0] rdata;
		logic speed_ok;
		logic [ADDR_W-1:0] ma;
		logic [1:0] ras_n;
		logic [3:0] cas_n;
		logic we_n;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
	} edc_ctrl_s;

	edc_ctrl_s s_q;
	edc_ctrl_s s_d;
	edc_tmr_if tmr ();

	edc_timer u_timer
	(
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.t(tmr.tmr)
	);

	function automatic logic [CNT_W-1:0] cyc8(input int n);
		cyc8 = CNT_W'(n);
	endfunction

	always_comb
	begin
		s_d = s_q;
		tmr.load = 1'b0;
		tmr.value = 8'h00;
		s_d.done = 1'b0;
		s_d.cyc = s_q.cyc + 8'h01;
		s_d.speed_ok = (i_speed_id == SPEED_ID_FAST) || (i_speed_id == SPEED_ID_SLOW);
		// ----------------------------------------------------------------
		// Refresh pacing
		// ----------------------------------------------------------------
		if (s_q.ref_cnt == REF_W'(REFRESH_INTERVAL_CYC - 1))
		begin
			s_d.ref_cnt = '0;
			s_d.ref_due = 1'b1;
		end
		else
			s_d.ref_cnt = s_q.ref_cnt + 12'h001;
		// ----------------------------------------------------------------
		// Access sequencer
		// ----------------------------------------------------------------
		case (s_q.st)
			ST_IDLE:
			begin
				// A stale ready must not accept a request while refresh is due.
				s_d.ready = !s_d.ref_due;
				if (s_q.ref_due)
				begin
					// CAS-before-RAS needs no row address, so no counter is kept.
					s_d.ready = 1'b0;
					s_d.cas_n = 4'h0;
					s_d.we_n = 1'b1;
					s_d.st = ST_REF_SET;
					s_d.cyc = 8'h01;
				end
				else if (i_req && s_q.ready)
				begin
					s_d.ready = 1'b0;
					s_d.we = i_we;
					s_d.addr = i_addr;
					s_d.be = i_be;
					s_d.ma = i_addr[WORD_ADDR_W-1:ADDR_W];
					s_d.we_n = !i_we;
					s_d.dq = i_wdata;
					s_d.dq_oe = i_we;
					s_d.st = ST_ROW;
				end
			end
			ST_ROW:
			begin
				s_d.ras_n = 2'b00;
				s_d.cyc = 8'h01;
				s_d.st = ST_COL;
			end
			ST_COL:
			begin
				if (s_q.cyc >= cyc8(CYC_ADDR_DLY) && s_q.cyc >= cyc8(CYC_ADDR_HOLD))
					s_d.ma = s_q.addr[ADDR_W-1:0];
				if (s_q.cyc >= cyc8(CYC_STB_DLY) && s_q.ma == s_q.addr[ADDR_W-1:0])
				begin
					// Only one column cycle per row opening, so column cycles stay far apart.
					s_d.cas_n = ~s_q.be;
					s_d.st = ST_HOLD;
					tmr.load = 1'b1;
					tmr.value = cyc8(CYC_COL_PULSE > CYC_ROW_HOLD_COL ? CYC_COL_PULSE : CYC_ROW_HOLD_COL);
				end
			end
			ST_HOLD:
			begin
				// Strobes release together once every hold and access time is met.
				if (tmr.done && s_q.cyc >= cyc8(CYC_ROW_PULSE) && s_q.cyc >= cyc8(CYC_COL_HOLD_ROW)
					&& s_q.cyc >= cyc8(CYC_ACCESS))
				begin
					if (!s_q.we)
						s_d.rdata = i_data_lines;
					s_d.ras_n = 2'b11;
					s_d.cas_n = 4'hf;
					s_d.we_n = 1'b1;
					s_d.dq_oe = 1'b0;
					s_d.done = 1'b1;
					s_d.st = ST_PRE;
					tmr.load = 1'b1;
					tmr.value = cyc8(CYC_ROW_PRE > CYC_COL_PRE ? CYC_ROW_PRE : CYC_COL_PRE);
				end
			end
			ST_PRE:
			begin
				// cyc still counts from row strobe fall for the full cycle minimum.
				if (tmr.done && s_q.cyc >= cyc8(CYC_FULL) && s_q.cyc >= cyc8(CYC_COL_TO_ROW))
				begin
					s_d.st = ST_IDLE;
					s_d.ready = !s_q.ref_due;
				end
			end
			ST_REF_SET:
			begin
				// Column strobes settle a cycle before the row strobe falls.
				s_d.ras_n = 2'b00;
				s_d.ref_due = 1'b0;
				s_d.cyc = 8'h01;
				s_d.st = ST_REF_ROW;
			end
			ST_REF_ROW:
			begin
				if (s_q.cyc >= cyc8(CYC_ROW_PULSE))
				begin
					s_d.ras_n = 2'b11;
					s_d.cas_n = 4'hf;
					s_d.st = ST_PRE;
					tmr.load = 1'b1;
					tmr.value = cyc8(CYC_ROW_PRE);
				end
			end
			default:
			begin
				s_d.st = ST_IDLE;
			end
		endcase
		// A refresh tick landing in the same cycle as a clear is kept.
		if (s_q.ref_cnt == REF_W'(REFRESH_INTERVAL_CYC - 1))
			s_d.ref_due = 1'b1;
		if (s_q.st != ST_IDLE && s_q.st != ST_PRE)
			s_d.ready = 1'b0;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.ras_n <= 2'b11;
			s_q.cas_n <= 4'hf;
			s_q.we_n <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign o_ready = s_q.ready;
	assign o_done = s_q.done;
	assign o_rdata = s_q.rdata;
	assign o_speed_ok = s_q.speed_ok;
	assign o_mux_addr_lines = s_q.ma;
	assign o_row_strobe_n = s_q.ras_n;
	assign o_col_strobe_n = s_q.cas_n;
	assign o_write_strobe_n = s_q.we_n;
	assign o_data_lines = s_q.dq;
	assign o_data_lines_oe = s_q.dq_oe;
endmodule

/* core/edc_pkg.sv */
// Purpose: Constants and types shared by the EDO DRAM module controller.
// Assumes: 125 MHz core clock, slower (70 ns) speed grade timing used for all cycles.
// Notes: Overview of operation and timing counts live here.
// Overview of operation
// - Issue 1,024 refresh cycles covering all rows within every 16 ms.
// - Module accepts CAS-before-RAS, row-only and hidden refresh; we use CAS-before-RAS.
// - Two row strobes, four column strobes, all active low; the row strobes are driven together, the column strobes per byte, all four together in refresh.
// - Row strobe to next row strobe at least 104 or 124 ns.
// - Row strobe stays inactive at least 40 or 50 ns between activations.
// - Row strobe low between 60 or 70 ns and 10,000 ns.
// - Column strobe low at least 10 or 12 ns, never past 10,000 ns.
// - Column strobe held low until 40 or 50 ns after row strobe fell.
// - Row strobe held low at least 10 or 12 ns after column strobe fell.
// - Column strobe stays high at least 10 ns before falling again.
// - Row strobe to column strobe at least 14 ns.
// - Column address presented at least 12 ns after row strobe falls.
// - At least 5 ns from column strobe release to next row strobe.
// - Row address valid at row strobe fall, held 10 ns afterwards.
// - Column address valid at column strobe fall, held 10 or 12 ns after.
// - Page mode column cycles no faster than 25 or 30 ns.
package edc_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int WORD_ADDR_W = 20;
	// Slow grade figures in ns; they satisfy the fast grade too.
	localparam int FULL_CYCLE_MIN_NS = 124;
	localparam int ROW_PRECHARGE_MIN_NS = 50;
	localparam int ROW_PULSE_MIN_NS = 70;
	localparam int COL_PULSE_MIN_NS = 12;
	localparam int COL_HOLD_AFTER_ROW_NS = 50;
	localparam int ROW_HOLD_AFTER_COL_NS = 12;
	localparam int COL_PRECHARGE_MIN_NS = 10;
	localparam int ROW_TO_COL_STROBE_NS = 14;
	localparam int ROW_TO_COL_ADDR_NS = 12;
	localparam int COL_TO_ROW_PRECHARGE_NS = 5;
	localparam int ROW_ADDR_HOLD_NS = 10;
	localparam int COL_ADDR_HOLD_NS = 12;
	localparam int ROW_ACCESS_NS = 70;
	localparam int REFRESH_PERIOD_MS = 16;
	localparam int REFRESH_ROWS = 1024;
	// Cycle counts; a minimum rounds up.
	localparam int CYC_ADDR_DLY = (ROW_TO_COL_ADDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_STB_DLY_RAW = (ROW_TO_COL_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_ADDR_HOLD = (ROW_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// The column strobe trails the column address by a cycle, so it also waits out the row address hold.
	localparam int CYC_STB_DLY = (CYC_STB_DLY_RAW > CYC_ADDR_HOLD + 1) ? CYC_STB_DLY_RAW : CYC_ADDR_HOLD + 1;
	localparam int CYC_ROW_PULSE = (ROW_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_COL_HOLD_ROW = (COL_HOLD_AFTER_ROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_COL_PULSE = (COL_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_ROW_HOLD_COL = (ROW_HOLD_AFTER_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_ACCESS = (ROW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_ROW_PRE = (ROW_PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_FULL = (FULL_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_COL_TO_ROW = (COL_TO_ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_COL_PRE = (COL_PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// A maximum interval rounds down.
	localparam int REFRESH_INTERVAL_CYC = (REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS;
	localparam int CNT_W = 8;
	localparam int REF_W = 12;
	localparam logic [3:0] SPEED_ID_FAST = 4'hc;
	localparam logic [3:0] SPEED_ID_SLOW = 4'h8;

	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_ROW = 7'h02,
		ST_COL = 7'h04,
		ST_HOLD = 7'h08,
		ST_PRE = 7'h10,
		ST_REF_SET = 7'h20,
		ST_REF_ROW = 7'h40
	} edc_state_e;
endpackage

/* core/edc_tmr_if.sv */
// Purpose: Carries the load and expiry of a down counter between controller and timer.
// Assumes: One clock domain.
// Notes: The controller owns load; the timer reports done.
`timescale 1ns/1ns
interface edc_tmr_if;
	logic load;
	logic [7:0] value;
	logic done;
	modport ctrl (output load, output value, input done);
	modport tmr (input load, input value, output done);
endinterface

/* core/edc_timer.sv */
// Purpose: Down counter that marks when a loaded interval has elapsed.
// Assumes: Loading N makes done rise N cycles later.
// Notes: Done stays high until the next load.
`timescale 1ns/1ns
module edc_timer
	import edc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	edc_tmr_if.tmr t
);
	typedef struct packed
	{
		logic [CNT_W-1:0] cnt;
	} edc_tmr_s;

	edc_tmr_s s_q;
	edc_tmr_s s_d;

	always_comb
	begin
		s_d = s_q;
		if (t.load)
			s_d.cnt = t.value - 8'h01;
		else if (s_q.cnt != 8'h00)
			s_d.cnt = s_q.cnt - 8'h01;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Done depends on the count alone: the controller raises load from done in the same cycle,
	// so feeding load back into done would close a combinational loop.
	assign t.done = (s_q.cnt == 8'h00);
endmodule

/* dv/edc_ctrl_sva.sv */
// Purpose: Strobe and address timing checks on the DRAM controller pins.
// Assumes: 8 ns clock; three cycle figures come from the package, the rest are written out.
// Notes: Strobe 0 of each group stands for its group.
`timescale 1ns/1ns
module edc_ctrl_sva
	import edc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [1:0] o_row_strobe_n,
	input wire logic [3:0] o_col_strobe_n,
	input wire logic [ADDR_W-1:0] o_mux_addr_lines
);
	logic [11:0] low_q;
	logic [11:0] since_q;
	wire logic ras = o_row_strobe_n[0];
	wire logic cas = o_col_strobe_n[0];
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);
	// The since counter starts high so the first activation after reset is not flagged.
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			low_q <= 12'h000;
			since_q <= 12'h0ff;
		end
		else
		begin
			low_q <= ras ? 12'h000 : low_q + 12'h001;
			since_q <= $fell(ras) ? 12'h001 : since_q + {11'h000, since_q != 12'hfff};
		end
	end
	a_row_pulse_min:
	assert property ($rose(ras) |-> low_q >= CYC_ROW_PULSE) else $error("row pulse short");
	a_row_pulse_max:
	assert property (!ras |-> low_q < 12'h4e2) else $error("row pulse long");
	a_row_precharge:
	assert property ($rose(ras) |-> ras[*7]) else $error("row precharge short");
	a_row_cycle_min:
	assert property ($fell(ras) |-> since_q >= CYC_FULL) else $error("row cycle short");
	a_col_pulse_min:
	assert property ($fell(cas) |-> (!cas)[*2]) else $error("column pulse short");
	a_col_hold_row:
	assert property ($rose(cas) && !$past(ras) |-> low_q >= CYC_COL_HOLD_ROW) else $error("column hold short");
	a_row_hold_col:
	assert property ($fell(cas) && !ras |-> (!ras)[*2]) else $error("row hold short");
	a_row_to_col:
	assert property ($fell(cas) && !ras |-> $past(ras, 2) == 1'b0) else $error("row to column short");
	a_col_addr_hold:
	assert property ($fell(cas) && !ras |-> $stable(o_mux_addr_lines)[*3]) else $error("column address moved");
endmodule

/* dv/edc_dram_model.sv */
// Purpose: Behavioural EDO DRAM module answering the controller pins.
// Assumes: Row strobe 0 stands for its group; the four column strobes are timed through their AND, each masking its own byte on writes; time unit 1 ns.
// Notes: Released data lines show the inverse of the last word, never a held value.
`timescale 1ns/1ns
module edc_dram_model
	import edc_pkg::*;
#(
	parameter bit SLOW = 1'b1
)
(
	input wire logic [ADDR_W-1:0] i_mux_addr_lines,
	input wire logic [1:0] i_row_strobe_n,
	input wire logic [3:0] i_col_strobe_n,
	input wire logic i_write_strobe_n,
	input wire logic [DATA_W-1:0] i_data_lines,
	output logic [DATA_W-1:0] o_data_lines,
	output logic [3:0] o_speed_id,
	output int o_refresh_cnt
);
	logic [DATA_W-1:0] mem [int];
	logic [ADDR_W-1:0] row;
	time tr;
	int a;
	assign o_speed_id = {1'b1, !SLOW, 2'b00};
	initial
	begin
		o_data_lines = 32'h0;
		o_refresh_cnt = 0;
	end
	always @(negedge i_row_strobe_n[0])
	begin
		tr = $time;
		if (&i_col_strobe_n)
			row = i_mux_addr_lines;
		else
			o_refresh_cnt++;
	end
	// Read data waits for the later of row access and column access, as a slow part would.
	always @(negedge (&i_col_strobe_n))
	begin
		if (!i_row_strobe_n[0])
		begin
			a = {row, i_mux_addr_lines};
			if (!mem.exists(a))
				mem[a] = 32'h0;
			if (!i_write_strobe_n)
			begin
				for (int b = 0; b < 4; b++)
					if (!i_col_strobe_n[b])
						mem[a][8*b+:8] = i_data_lines[8*b+:8];
			end
			else
				o_data_lines <= #(($time - tr > 35) ? 35 : 70 - ($time - tr)) mem[a];
		end
	end
	always @(posedge (&i_col_strobe_n))
		o_data_lines <= ~o_data_lines;
endmodule

/* dv/edc_ctrl_test.sv */
// Purpose: Self-checking bench for the DRAM controller against a module model.
// Assumes: 125 MHz clock; slow-grade module fitted.
// Notes: The refresh check runs just over eight refresh intervals.
`timescale 1ns/1ns
`define CHK(n, e, g) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("Error %s expected %h seen %h", n, e, g); \
		end \
	end
module edc_ctrl_test
	import edc_pkg::*;
;
	logic clk = 1'b0;
	logic rstn, req, we, ready, done, ok, wen, oe;
	logic [WORD_ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, wd, md;
	logic [3:0] be, sid, cas;
	logic [ADDR_W-1:0] mux;
	logic [1:0] ras;
	wire logic [DATA_W-1:0] dq = oe ? wd : md;
	int refs;
	int err_total = 0;
	int tests_run = 0;
	always #4 clk = ~clk;
	edc_ctrl dut (.i_core_clk(clk), .i_rstn(rstn), .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata),
		.i_be(be), .i_data_lines(dq), .i_speed_id(sid), .o_ready(ready), .o_done(done), .o_rdata(rdata),
		.o_speed_ok(ok), .o_mux_addr_lines(mux), .o_row_strobe_n(ras), .o_col_strobe_n(cas),
		.o_write_strobe_n(wen), .o_data_lines(wd), .o_data_lines_oe(oe));
	edc_dram_model u_mem (.i_mux_addr_lines(mux), .i_row_strobe_n(ras), .i_col_strobe_n(cas),
		.i_write_strobe_n(wen), .i_data_lines(dq), .o_data_lines(md), .o_speed_id(sid), .o_refresh_cnt(refs));
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic access(input logic w, input logic [19:0] ad, input logic [31:0] d, input logic [3:0] b);
		int n;
		@(negedge clk);
		{we, addr, wdata, be, req} = {w, ad, d, b, 1'b1};
		for (n = 0; n < 2000 && ready !== 1'b1; n++)
			@(negedge clk);
		@(negedge clk);
		req = 1'b0;
		`CHK("ready", 1'b0, ready)
		`CHK("oe", w, oe)
		`CHK("we_n", !w, wen)
		for (n = 0; n < 40 && done !== 1'b1; n++)
			@(negedge clk);
		`CHK("done", 1'b1, done)
	endtask
	task automatic rd(input logic [19:0] ad, input logic [31:0] e);
		access(1'b0, ad, 32'h0, 4'hf);
		`CHK("rdata", e, rdata)
	endtask
	task automatic t_reset();
		rstn = 1'b0;
		repeat (8) @(posedge clk);
		`CHK("strobes", 6'h3f, {ras, cas})
		`CHK("oe", 1'b0, oe)
		`CHK("ready", 1'b0, ready)
		@(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("ready", 1'b1, ready)
		`CHK("speed_ok", 1'b1, ok)
		$display("reset test done");
	endtask
	task automatic t_rw();
		access(1'b1, 20'hfffff, 32'hdeadbeef, 4'hf);
		access(1'b1, 20'h00000, 32'h01234567, 4'hf);
		access(1'b1, 20'hfffff, 32'h11223344, 4'h5);
		rd(20'h00000, 32'h01234567);
		rd(20'hfffff, 32'hde22be44);
		$display("read write test done");
	endtask
	task automatic t_refresh();
		int r0;
		r0 = refs;
		repeat (16000) @(negedge clk);
		`CHK("refresh", 1'b1, (refs - r0) >= 16000 / REFRESH_INTERVAL_CYC)
		rd(20'hfffff, 32'hde22be44);
		$display("refresh test done");
	endtask
	initial
	begin
		{req, we, addr, wdata, be} = '0;
		t_reset();
		t_rw();
		t_refresh();
		end_sim();
	end
	initial
	begin
		#(8 * 20000);
		err_total++;
		$display("Error watchdog expected finish seen timeout");
		end_sim();
	end
endmodule
bind edc_ctrl edc_ctrl_sva u_sva (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .o_row_strobe_n(o_row_strobe_n),
	.o_col_strobe_n(o_col_strobe_n), .o_mux_addr_lines(o_mux_addr_lines));
